// File: core/pdsc_power_control.v
// Power-down and sleep controller of the processor core.
// Assumes: I/O write requests from the core on mclk, the bus arbiter
// grant on a pin, interrupt requests on pins, register port on mclk.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pdsc_defines.vh"

module pdsc_power_control
(
    input  wire        mclk,         // System clock, 100 MHz
    input  wire        rst,          // Synchronous reset, active high
    input  wire        extResetPin,  // External reset pin, active high
    input  wire [3:0]  irqPin,       // Interrupt request pins, active high
    input  wire        busGrantPin,  // Bus grant from external arbiter
    input  wire        ioWrReq,      // Core requests an I/O write
    input  wire [31:0] ioAddr,       // Address of the I/O access
    input  wire        ioRdReq,      // Core requests an I/O or memory load
    input  wire        depWait,      // Next instruction depends on that load
    input  wire        intLock,      // Interrupt lock flag of the status word
    input  wire [3:0]  regAddr,      // Register port address
    input  wire [31:0] regWdata,     // Register port write data
    input  wire        regWr,        // Register port write strobe
    input  wire        regRd,        // Register port read strobe
    output reg  [31:0] regRdata,     // Register port read data
    output reg         busReq,       // Bus request to the arbiter
    output reg         ioDone,       // Pulse: I/O access performed
    output reg         pipeRun,      // Instruction pipeline enable
    output reg         coreClkEn,    // Gate for the general core clock
    output reg         keepClkEn,    // Gate for timer, pin, interrupt, refresh
    output reg         oscEnable,    // Crystal oscillator enable
    output reg         coreReset,    // Reset to the core during the sequence
    output reg         irqTake,      // High while an interrupt may be serviced
    output reg         timeUnit,     // Timer time unit pulse
    output reg  [1:0]  clkDivSel,    // Processor clock divider select
    output reg  [31:0] fcwOut        // Function control word in force
);

    localparam ST_RUN   = 3'h0;
    localparam ST_PDWN  = 3'h1;
    localparam ST_SLEEP = 3'h2;
    localparam ST_RSEQ  = 3'h3;
    localparam ST_SVC   = 3'h4;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    reg  [5:0] sync1_r;
    reg  [5:0] sync2_r;
    always @(posedge mclk)
    begin
        if (rst)
        begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end
        else
        begin
            sync1_r <= {busGrantPin, extResetPin, irqPin};
            sync2_r <= sync1_r;
        end
    end
    wire [3:0] irqS    = sync2_r[3:0];
    wire       extRstS = sync2_r[4];
    wire       grantS  = sync2_r[5];
    wire       anyIrq  = |irqS;

    // --------------------------------------------------------------
    // Mode request decode
    // --------------------------------------------------------------
    wire [3:0] modeBits = ioAddr[`PDSC_IOA_MODE_HI:`PDSC_IOA_MODE_LO];
    wire       pdHit    = ioWrReq && ioAddr[`PDSC_IOA_SEL_BIT]
                          && (modeBits == `PDSC_IOA_PD_CODE);
    wire       slHit    = ioWrReq && ioAddr[`PDSC_IOA_SEL_BIT]
                          && (modeBits == `PDSC_IOA_SLEEP_CODE);

    // --------------------------------------------------------------
    // State and registers
    // --------------------------------------------------------------
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         wrPend_r;
    reg  [1:0]  wrKind_r;
    reg         rdPend_r;
    reg         wakeSleep_r;
    reg         wakeByIrq_r;
    reg         irqDefer_r;
    reg  [7:0]  seqCnt_r;
    reg  [31:0] fcw_r;
    reg         pcwWr_r;
    reg  [31:0] pcwWdata_r;
    reg         refreshTick_r;
    reg  [7:0]  refreshCnt_r;
    reg         blip_r;
    wire [31:0] pcwActive;
    wire        pendingUpd;
    wire        tuPulse;

    // Access is performed only when the bus is granted
    wire accessNow = grantS && busReq && (wrPend_r || rdPend_r);
    wire pdEnter   = accessNow && wrPend_r && (wrKind_r == 2'h1);
    wire slEnter   = accessNow && wrPend_r && (wrKind_r == 2'h2);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
                if (slEnter)
                    state_nxt = ST_SLEEP;
                else if (pdEnter)
                    state_nxt = ST_PDWN;
            ST_PDWN:
                if (anyIrq)
                    state_nxt = ST_RUN;
            ST_SLEEP:
                if (anyIrq || extRstS)
                    state_nxt = ST_RSEQ;
            ST_RSEQ:
                if (seqCnt_r == `PDSC_RST_SEQ_CYCLES)
                    state_nxt = ST_RUN;
            default:
                state_nxt = ST_RUN;
        endcase
        if (extRstS && state_r != ST_SLEEP)
            state_nxt = ST_RSEQ;
    end

    // --------------------------------------------------------------
    // Main sequencing
    // --------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            state_r       <= ST_RUN;
            wrPend_r      <= 1'b0;
            wrKind_r      <= 2'h0;
            rdPend_r      <= 1'b0;
            wakeSleep_r   <= 1'b0;
            wakeByIrq_r   <= 1'b0;
            irqDefer_r    <= 1'b0;
            seqCnt_r      <= 8'h00;
            fcw_r         <= `PDSC_FCW_RESET;
            refreshCnt_r  <= 8'h00;
            refreshTick_r <= 1'b0;
            blip_r        <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == ST_RUN && ioWrReq && !wrPend_r)
            begin
                wrPend_r <= 1'b1;
                wrKind_r <= slHit ? 2'h2 : (pdHit ? 2'h1 : 2'h0);
            end
            else if (accessNow && wrPend_r)
                wrPend_r <= 1'b0;
            if (state_r == ST_RUN && ioRdReq && !rdPend_r)
                rdPend_r <= 1'b1;
            else if (accessNow && !wrPend_r)
                rdPend_r <= 1'b0;
            if (state_r == ST_SLEEP && state_nxt == ST_RSEQ)
            begin
                wakeSleep_r <= 1'b1;
                wakeByIrq_r <= anyIrq && !extRstS;
                rdPend_r    <= 1'b0;
                wrPend_r    <= 1'b0;
            end
            else if (regWr && regAddr == `PDSC_REG_WAKE && regWdata[`PDSC_WAKE_SLEEP_BIT])
                wakeSleep_r <= 1'b0;
            // A pin reset never keeps the control word of an older irq wake
            if (extRstS && state_r != ST_SLEEP)
                wakeByIrq_r <= 1'b0;
            // Sequence length counts from the release of the reset pin
            if (state_r == ST_RSEQ && !extRstS)
                seqCnt_r <= seqCnt_r + 8'h01;
            else
                seqCnt_r <= 8'h00;
            if (state_r == ST_RSEQ && seqCnt_r == 8'h00 && !wakeByIrq_r)
                fcw_r <= `PDSC_FCW_RESET;
            else if (regWr && regAddr == `PDSC_REG_FCW)
                fcw_r <= regWdata;
            // Wake with lock set: resume now, service later
            if (state_r == ST_PDWN && anyIrq && intLock)
                irqDefer_r <= 1'b1;
            else if (!intLock || !anyIrq)
                irqDefer_r <= 1'b0;
            refreshCnt_r  <= refreshCnt_r + 8'h01;
            refreshTick_r <= (refreshCnt_r == 8'hFF);
            blip_r        <= (state_r == ST_PDWN) && (refreshTick_r || grantS);
        end
    end

    // --------------------------------------------------------------
    // Prescaler word and delayed update
    // --------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pcwWr_r    <= 1'b0;
            pcwWdata_r <= 32'h00000000;
        end
        else
        begin
            pcwWr_r    <= regWr && (regAddr == `PDSC_REG_PCW);
            pcwWdata_r <= regWdata;
        end
    end

    pdsc_prescaler_update u_pre
    (
        .mclk       (mclk),
        .rst        (rst),
        .run        (state_r != ST_SLEEP),
        .pcwWrite   (pcwWr_r),
        .pcwData    (pcwWdata_r),
        .pcwActive  (pcwActive),
        .pendingUpd (pendingUpd),
        .timeUnit   (tuPulse)
    );

    // --------------------------------------------------------------
    // Registered outputs
    // --------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            busReq    <= 1'b0;
            ioDone    <= 1'b0;
            pipeRun   <= 1'b0;
            coreClkEn <= 1'b1;
            keepClkEn <= 1'b1;
            oscEnable <= 1'b1;
            coreReset <= 1'b1;
            irqTake   <= 1'b0;
            timeUnit  <= 1'b0;
            clkDivSel <= 2'h2;
            fcwOut    <= `PDSC_FCW_RESET;
        end
        else
        begin
            // Arbiter grant completes the pending access
            busReq    <= (state_nxt == ST_RUN) && (wrPend_r || rdPend_r || ioWrReq || ioRdReq)
                         && !accessNow;
            ioDone    <= accessNow;
            // Stall dependent instruction until accesses finish
            pipeRun   <= (state_nxt == ST_RUN) && !(depWait && (wrPend_r || rdPend_r));
            coreClkEn <= (state_nxt == ST_RUN) || blip_r;
            keepClkEn <= (state_nxt != ST_SLEEP);
            oscEnable <= (state_nxt != ST_SLEEP);
            coreReset <= (state_nxt == ST_SLEEP) || (state_nxt == ST_RSEQ);
            irqTake   <= (state_r == ST_RUN) && anyIrq && !intLock && !irqDefer_r;
            timeUnit  <= tuPulse;
            clkDivSel <= pcwActive[`PDSC_PCW_DIV_HI:`PDSC_PCW_DIV_LO];
            fcwOut    <= fcw_r;
        end
    end

    // --------------------------------------------------------------
    // Register read port
    // --------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
            regRdata <= 32'h00000000;
        else if (regRd && regAddr == `PDSC_REG_STATUS)
            regRdata <= {26'h0, pendingUpd, irqDefer_r, rdPend_r, wrPend_r, state_r == ST_PDWN, state_r == ST_RUN};
        else if (regRd && regAddr == `PDSC_REG_PCW)
            regRdata <= pcwActive;
        else if (regRd && regAddr == `PDSC_REG_FCW)
            regRdata <= fcw_r;
        else if (regRd && regAddr == `PDSC_REG_WAKE)
            regRdata <= {21'h0, wakeSleep_r, 10'h0};
        else
            regRdata <= 32'h00000000;
    end

endmodule

// File: core/pdsc_defines.vh
// Constants for the power-down and sleep controller.
// Included by the controller and its prescaler update unit.
`ifndef PDSC_DEFINES_VH
`define PDSC_DEFINES_VH

// I/O address decode (bit positions)
`define PDSC_IOA_SEL_BIT     27
`define PDSC_IOA_MODE_HI     25
`define PDSC_IOA_MODE_LO     22
`define PDSC_IOA_PD_CODE     4'hE
`define PDSC_IOA_SLEEP_CODE  4'hF

// Prescaler control word fields
`define PDSC_PCW_DELAY_BIT   31
`define PDSC_PCW_DIV_HI      27
`define PDSC_PCW_DIV_LO      26
`define PDSC_PCW_PRE_HI      23
`define PDSC_PCW_PRE_LO      16
`define PDSC_PCW_RESET       32'h08000000

// Wake cause bit in the wake register
`define PDSC_WAKE_SLEEP_BIT  10

// Function control word reset value
`define PDSC_FCW_RESET       32'h00800000

// Reset sequence length after a wake from sleep
`define PDSC_RST_SEQ_CYCLES  8'h10

// Register port offsets
`define PDSC_REG_CTRL        4'h0
`define PDSC_REG_STATUS      4'h1
`define PDSC_REG_PCW         4'h2
`define PDSC_REG_FCW         4'h3
`define PDSC_REG_WAKE        4'h4

`endif

// File: core/pdsc_prescaler_update.v
// Prescaler unit: timer time unit generator with delayed divider update.
// Assumes a single clock mclk and a one-cycle write pulse for a new word.
`timescale 1ns/1ps
`include "pdsc_defines.vh"

module pdsc_prescaler_update
(
    input  wire        mclk,        // System clock
    input  wire        rst,         // Synchronous reset, active high
    input  wire        run,         // Prescaler counts while high
    input  wire        pcwWrite,    // New prescaler control word pulse
    input  wire [31:0] pcwData,     // New prescaler control word
    output reg  [31:0] pcwActive,   // Word currently in force
    output reg         pendingUpd,  // A delayed update is waiting
    output reg         timeUnit     // One-cycle pulse at end of time unit
);

    reg [31:0] pcwPend_r;
    reg [7:0]  cnt_r;
    wire       unitEnd = run && (cnt_r == pcwActive[`PDSC_PCW_PRE_HI:`PDSC_PCW_PRE_LO] + 8'h01);

    // --------------------------------------------------------------
    // Divide by n+2, update immediately or at the end of a time unit
    // --------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pcwActive  <= `PDSC_PCW_RESET;
            pcwPend_r  <= `PDSC_PCW_RESET;
            pendingUpd <= 1'b0;
            cnt_r      <= 8'h00;
            timeUnit   <= 1'b0;
        end
        else
        begin
            timeUnit <= unitEnd;
            if (unitEnd)
                cnt_r <= 8'h00;
            else if (run)
                cnt_r <= cnt_r + 8'h01;
            if (pcwWrite && !pcwData[`PDSC_PCW_DELAY_BIT])
            begin
                pcwActive  <= pcwData;
                pendingUpd <= 1'b0;
                cnt_r      <= 8'h00;
            end
            else if (pcwWrite)
            begin
                pcwPend_r  <= pcwData;
                pendingUpd <= 1'b1;
            end
            else if (pendingUpd && unitEnd)
            begin
                pcwActive  <= pcwPend_r;
                pendingUpd <= 1'b0;
            end
        end
    end

endmodule

// File: tb/pdsc_power_control_asserts.sv
// Checker for the power-down and sleep controller, bound to its ports.
// Assumes one clock mclk and the synchronous reset rst.
`timescale 1ns/1ps

module pdsc_power_control_asserts
(
    input wire        mclk,       // System clock
    input wire        rst,        // Synchronous reset
    input wire        extResetPin,// External reset
    input wire [3:0]  irqPin,     // Interrupt lines
    input wire        intLock,    // Interrupt lock
    input wire        busReq,     // Bus request
    input wire        ioDone,     // Access performed
    input wire        pipeRun,    // Pipeline enable
    input wire        coreClkEn,  // Core clock gate
    input wire        keepClkEn,  // Kept clock gate
    input wire        oscEnable,  // Oscillator enable
    input wire        coreReset,  // Core reset
    input wire        irqTake,    // Interrupt serviceable
    input wire [31:0] fcwOut      // Function control word
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_pdwn_gates:
        assert property ($fell(coreClkEn) && oscEnable |-> !pipeRun && keepClkEn)
        else $error("gating wrong at power-down");
    a_halt_no_exec: assert property (!coreClkEn |-> !pipeRun)
        else $error("pipeline runs while halted");
    a_pdwn_wake:
        assert property (!coreClkEn && oscEnable && !coreReset && irqPin != 4'h0
            |-> ##[1:8] pipeRun)
        else $error("interrupt did not end power-down");
    a_done_granted: assert property (ioDone |-> $past(busReq))
        else $error("access performed without request");
    a_done_pulse: assert property (ioDone |=> !ioDone)
        else $error("access pulse too long");
    a_sleep_entry:
        assert property (ioDone && !oscEnable |-> coreReset && !busReq && !pipeRun)
        else $error("sleep entry wrong");
    a_sleep_quiet: assert property (!oscEnable |-> !busReq && !coreClkEn)
        else $error("activity during sleep");
    a_wake_reset: assert property ($rose(oscEnable) |-> coreReset [*8])
        else $error("wake did not run reset sequence");
    a_fcw_kept:
        assert property ($rose(oscEnable) && irqPin != 4'h0 && !extResetPin
            |-> $stable(fcwOut) [*8])
        else $error("control word lost on wake");
    a_lock_defer: assert property (intLock && $past(intLock) |-> !irqTake)
        else $error("interrupt taken while locked");
endmodule

bind pdsc_power_control pdsc_power_control_asserts u_pdsc_power_control_asserts
(
    .mclk, .rst, .extResetPin, .irqPin, .intLock, .busReq, .ioDone, .pipeRun,
    .coreClkEn, .keepClkEn, .oscEnable, .coreReset, .irqTake, .fcwOut
);

// File: tb/pdsc_partner_model.sv
// Partner model: external bus arbiter and interrupt source.
// Assumes the block's busReq and irqTake levels on mclk.
`timescale 1ns/1ps

module pdsc_partner_model
(
    input  wire       mclk,        // System clock
    input  wire       rst,         // Synchronous reset
    input  wire       busReq,      // Bus request
    input  wire       slowGrant,   // Grant after a wait
    input  wire       irqTake,     // Interrupt accepted
    input  wire       irqRaise,    // Start an interrupt
    input  wire       irqDrop,     // Withdraw it
    output reg        busGrantPin, // Grant
    output reg  [3:0] irqPin       // Interrupt lines
);
    reg [2:0] waitCnt_r;
    reg       takeSeen_r;

    // Grant follows the request at once or after five cycles
    always @(posedge mclk)
    begin
        if (rst || !busReq)
        begin
            waitCnt_r   <= 3'h0;
            busGrantPin <= 1'b0;
        end
        else
        begin
            waitCnt_r   <= waitCnt_r + {2'h0, waitCnt_r != 3'h7};
            busGrantPin <= waitCnt_r >= (slowGrant ? 3'h5 : 3'h0);
        end
    end

    // Request held until accepted or withdrawn, so it outlasts the wake reset
    always @(posedge mclk)
    begin
        takeSeen_r <= irqTake;
        if (rst || irqDrop || (irqTake && !takeSeen_r))
            irqPin <= 4'h0;
        else if (irqRaise)
            irqPin <= 4'h1;
    end
endmodule

// File: tb/pdsc_power_control_tb_top.sv
// Self-checking bench for the power-down and sleep controller.
// Assumes the core files, the partner model and the bound checker.
`timescale 1ns/1ps
`include "pdsc_defines.vh"

module pdsc_power_control_tb_top;
    reg         mclk, rst, ioWrReq, ioRdReq, depWait, intLock, regWr, regRd;
    reg         slowGrant, irqRaise, irqDrop, extRst;
    reg  [31:0] ioAddr, regWdata;
    reg  [3:0]  regAddr;
    wire [31:0] regRdata, fcwOut;
    wire [3:0]  irqPin;
    wire [1:0]  clkDivSel;
    wire        busGrantPin, busReq, ioDone, pipeRun, coreClkEn, keepClkEn;
    wire        oscEnable, coreReset, irqTake, timeUnit;
    wire [31:0] st = {22'h0, irqTake, clkDivSel, busReq, ioDone, pipeRun,
                      coreClkEn, keepClkEn, oscEnable, coreReset};
    integer     n_mismatch, checked, i, j;

    pdsc_power_control u_pdsc_power_control
    (
        .mclk, .rst, .extResetPin(extRst), .irqPin, .busGrantPin, .ioWrReq, .ioAddr,
        .ioRdReq, .depWait, .intLock, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .busReq, .ioDone, .pipeRun, .coreClkEn, .keepClkEn, .oscEnable,
        .coreReset, .irqTake, .timeUnit, .clkDivSel, .fcwOut
    );

    pdsc_partner_model u_pdsc_partner_model
    (
        .mclk, .rst, .busReq, .slowGrant, .irqTake, .irqRaise, .irqDrop,
        .busGrantPin, .irqPin
    );

    task chk(input string nm, input [31:0] e, input [31:0] g);
        checked = checked + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task waitEv(input integer b, input v, input string nm);
        j = 0;
        do
        begin
            @(posedge mclk);
            #1;
            j = j + 1;
        end while (st[b] !== v && j < 200);
        chk(nm, {31'h0, v}, {31'h0, st[b]});
    endtask

    task wrReg(input [3:0] a, input [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr    <= 1'b0;
    endtask

    task rdReg(input [3:0] a, input [31:0] e, input string nm);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1;
        chk(nm, e, regRdata);
    endtask

    task ioWr(input [31:0] a, input s);
        @(posedge mclk);
        slowGrant <= s;
        ioAddr    <= a;
        ioWrReq   <= 1'b1;
        @(posedge mclk);
        ioWrReq   <= 1'b0;
    endtask

    task irq(input [1:0] v);
        @(posedge mclk);
        {irqRaise, irqDrop} <= v;
        @(posedge mclk);
        {irqRaise, irqDrop} <= 2'h0;
    endtask

    task t_regs;
        wrReg(4'hF, 32'hFFFFFFFF);
        rdReg(4'hF, 32'h0, "unmapped");
        rdReg(`PDSC_REG_PCW, `PDSC_PCW_RESET, "pcw reset");
        rdReg(`PDSC_REG_FCW, `PDSC_FCW_RESET, "fcw reset");
        $display("test regs done");
    endtask

    task t_decode;
        for (i = 0; i < 3; i = i + 1)
        begin
            ioWr(i == 0 ? 32'h0B000000 : i == 1 ? 32'h03800000 : 32'h03C00000, 1'b0);
            repeat (20) @(posedge mclk);
            #1;
            chk("near miss", 32'h12, st & 32'h12);
        end
        $display("test decode done");
    endtask

    task t_pdwn;
        ioWr(32'h0B800000, 1'b1);
        ioRdReq <= 1'b1;
        depWait <= 1'b1;
        @(posedge mclk);
        ioRdReq <= 1'b0;
        waitEv(5, 1'b1, "pdwn done");
        chk("pdwn gates", 32'h26, st & 32'h3E);
        i = 0;
        repeat (300)
        begin
            @(posedge mclk);
            #1;
            i = i + (pipeRun !== 1'b0);
        end
        chk("runs in pdwn", 32'h0, i);
        @(posedge mclk);
        depWait <= 1'b0;
        irq(2'h2);
        waitEv(4, 1'b1, "wake");
        irq(2'h1);
        $display("test power-down done");
    endtask

    task t_lock;
        @(posedge mclk);
        intLock <= 1'b1;
        ioWr(32'h0B800000, 1'b0);
        waitEv(5, 1'b1, "pdwn done");
        irq(2'h2);
        waitEv(4, 1'b1, "locked wake");
        repeat (10) @(posedge mclk);
        #1;
        chk("deferred", 32'h0, st & 32'h200);
        @(posedge mclk);
        intLock <= 1'b0;
        waitEv(9, 1'b1, "irq taken");
        irq(2'h1);
        $display("test lock done");
    endtask

    task t_sleep;
        wrReg(`PDSC_REG_FCW, 32'h00A5005A);
        ioWr(32'h0BC00000, 1'b0);
        waitEv(5, 1'b1, "sleep done");
        chk("sleep entry", 32'h21, st & 32'h63);
        repeat (30) @(posedge mclk);
        #1;
        chk("asleep", 32'h01, st & 32'h63);
        irq(2'h2);
        waitEv(0, 1'b0, "reset seq");
        chk("fcw kept", 32'h00A5005A, fcwOut);
        rdReg(`PDSC_REG_WAKE, 32'h1 << `PDSC_WAKE_SLEEP_BIT, "wake flag");
        wrReg(`PDSC_REG_WAKE, 32'h1 << `PDSC_WAKE_SLEEP_BIT);
        rdReg(`PDSC_REG_WAKE, 32'h0, "wake clear");
        irq(2'h1);
        $display("test sleep done");
    endtask

    task t_pcw;
        wrReg(`PDSC_REG_PCW, 32'h0CC80000);
        repeat (3) @(posedge mclk);
        #1;
        chk("div now", 32'h3, {30'h0, clkDivSel});
        wrReg(`PDSC_REG_PCW, 32'h80050000);
        repeat (3) @(posedge mclk);
        #1;
        chk("div held", 32'h3, {30'h0, clkDivSel});
        repeat (210) @(posedge mclk);
        #1;
        chk("div late", 32'h0, {30'h0, clkDivSel});
        i = 0;
        repeat (70)
        begin
            @(posedge mclk);
            #1;
            i = i + (timeUnit === 1'b1);
        end
        chk("time units", 32'd10, i);
        $display("test prescaler done");
    endtask

    task t_extrst;
        wrReg(`PDSC_REG_FCW, 32'h00A5005A);
        ioWr(32'h0BC00000, 1'b0);
        waitEv(5, 1'b1, "sleep done");
        repeat (5) @(posedge mclk);
        extRst <= 1'b1;
        repeat (3) @(posedge mclk);
        extRst <= 1'b0;
        waitEv(0, 1'b0, "ext wake");
        chk("fcw reset", `PDSC_FCW_RESET, fcwOut);
        rdReg(`PDSC_REG_WAKE, 32'h1 << `PDSC_WAKE_SLEEP_BIT, "ext wake flag");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        chk("mid reset outs", 32'h10F, st & 32'h1FF);
        @(posedge mclk);
        rst <= 1'b0;
        waitEv(4, 1'b1, "rerun");
        rdReg(`PDSC_REG_WAKE, 32'h0, "flag after reset");
        $display("test external reset done");
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run takes about a thousand cycles
    initial
    begin
        #200000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end

    initial
    begin
        {rst, ioWrReq, ioRdReq, depWait, intLock, regWr, regRd} = 7'h40;
        {slowGrant, irqRaise, irqDrop} = 3'h0;
        extRst = 1'b0;
        {ioAddr, regWdata, regAddr} = 68'h0;
        n_mismatch = 0;
        checked = 0;
        repeat (11) @(posedge mclk);
        #1;
        chk("reset outs", 32'h10F, st & 32'h1FF);
        chk("reset fcw", `PDSC_FCW_RESET, fcwOut);
        @(posedge mclk);
        rst <= 1'b0;
        waitEv(4, 1'b1, "running");
        t_regs;
        t_decode;
        t_pdwn;
        t_lock;
        t_sleep;
        t_extrst;
        t_pcw;
        report_and_stop;
    end
endmodule
